// >>> core/adcs_pkg.sv
/*
  Constants, register map, field positions and carrier types for the channel and
  reference selection sequencer of a successive-approximation converter.
  Assumes a Wishbone classic slave with 32-bit data and byte addressing.
*/
// Notes on behaviour
// RQ1 - Selection writes go to a holding register, applied until a conversion starts.
// RQ2 - Copying resumes in the final ADC clock cycle, when the done flag sets.
// RQ3 - Software waits one ADC clock after setting start before new selection writes.
// RQ4 - Under auto-trigger, change selection only in the safe windows; applies next conversion.
// RQ5 - Software waits 125 us after selecting a new differential channel.
// RQ6 - Same 125 us wait for the first differential conversion after a reference change.
// RQ7 - Free running: next result uses old channel, later results use new one.
// RQ8 - Every amplified conversion clears the start bit at its end.
// RQ9 - Software discards first result after gain channel or reference change.
// RQ10 - Reference select chooses supply, internal 2.56V, or external reference pin.
// RQ11 - Single-ended results above reference saturate at full scale code.
// RQ12 - Current source output disconnects the reference pin from the internal network.
// RQ13 - Idle or noise-reduction sleep starts a conversion once the CPU halts.
// RQ14 - Sleep-started conversion still raises completion request after an early wake.
// RQ15 - Converter stays powered in other sleep modes; software clears enable itself.
// RQ16 - Same input may be both differential inputs, for offset measurement.
// RQ17 - Software does not change selections while free running.
// RQ18 - Completion writes result, sets done flag, clears start in single mode.
// RQ19 - Normal conversion takes 13 ADC clocks, first after enable takes 25.
// RQ20 - Applied selection samples the holding register on ADC edges when idle or final.
package adcs_pkg;

  localparam logic [4:0] OFS_SELECT = 5'h00;
  localparam logic [4:0] OFS_CTRL_A = 5'h04;
  localparam logic [4:0] OFS_CTRL_B = 5'h08;
  localparam logic [4:0] OFS_RESULT = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  // input_select_reg fields
  localparam int CH_LSB = 0;
  localparam int REF_LSB = 6;
  // converter_ctrl_a fields
  localparam int BIT_EN = 7;
  localparam int BIT_START = 6;
  localparam int BIT_ATE = 5;
  localparam int BIT_DONE = 4;
  localparam int BIT_IE = 3;
  localparam int PS_LSB = 0;
  // converter_ctrl_b fields
  localparam int BIT_REFPIN = 5;
  localparam int BIT_CURRENT_SOURCE_OUTPUT = 4;
  localparam int BIT_TRIGEXT = 0;

  localparam logic [7:0] RST_SELECT = 8'h00;
  localparam logic [2:0] RST_PS = 3'h0;
  localparam logic [9:0] FULL_SCALE = 10'h3FF;

  localparam logic [4:0] CYC_NORMAL = 5'd13;
  localparam logic [4:0] CYC_FIRST = 5'd25;
  localparam logic [4:0] SH_NORMAL = 5'd3;
  localparam logic [4:0] SH_FIRST = 5'd13;

  // Channel codes from here upward go through the gain stage
  localparam logic [3:0] AMP_CH_FIRST = 4'hB;
  // Positive and negative input on the same pin
  localparam logic [3:0] CH_DIFF_SAME = 4'hE;

  localparam logic [1:0] REF_PIN = 2'h0;
  localparam logic [1:0] REF_AVCC = 2'h1;
  localparam logic [1:0] REF_INT = 2'h3;

  typedef enum logic {ST_IDLE = 1'b0, ST_CONV = 1'b1} adcs_state_e;

  typedef enum logic [1:0] {
    SLP_NONE = 2'h0,
    SLP_IDLE = 2'h1,
    SLP_NR = 2'h3,
    SLP_DEEP = 2'h2
  } adcs_sleep_e;

  typedef struct packed {
    logic [3:0] channel;
    logic ref_avcc;
    logic ref_int;
    logic ref_pin_connect;
    logic current_source_output_drive;
    logic powered;
    logic sample_strobe;
  } adcs_analog_s;

endpackage : adcs_pkg

// >>> core/adcs_sync.sv
/*
  Two flip-flop synchroniser for level inputs.
  Assumes the input is a slowly changing pin level.
*/
`timescale 1ns/1ns
`default_nettype none
module adcs_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule : adcs_sync
`default_nettype wire

// >>> core/adcs_presc.sv
/*
  ADC clock prescaler: a one-cycle tick every 2 << sel system clocks.
  Assumes enable low holds it in reset and restart realigns it to a trigger.
*/
`timescale 1ns/1ns
`default_nettype none
module adcs_presc #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic enable,
  input wire logic restart,
  input wire logic [2:0] sel,
  output logic tick
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] top;

  assign top = W'((2 << sel) - 1);
  assign tick = enable && !restart && (cnt_ff == top);

  always_ff @(posedge clk_sys) begin
    if (!nrst || !enable || restart || tick) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + W'(1);
    end
  end

endmodule : adcs_presc
`default_nettype wire

// >>> core/adcs_sequencer.sv
/*
  Channel and reference selection sequencer with conversion timing, start sources
  (software, external trigger, free running, sleep) and a Wishbone classic slave.
  Assumes sample_in is the front end's code on clk_sys, valid at the strobe,
  and that sleep_mode and cpu_halted come from the core on the same clock.
*/
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module adcs_sequencer (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_trigger,
  input wire logic [11:0] sample_in,
  input wire adcs_pkg::adcs_sleep_e sleep_mode,
  input wire logic cpu_halted,
  output adcs_pkg::adcs_analog_s analog_o,
  output logic conv_done_irq,
  output logic busy
);
  import adcs_pkg::*;

  // Bus side
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic req;
  logic wr_fire;
  logic wr_lane0;

  // Software visible state
  logic [7:0] sel_hold_ff;
  logic [7:0] applied_ff;
  logic en_ff;
  logic start_ff;
  logic ate_ff;
  logic done_ff;
  logic ie_ff;
  logic [2:0] ps_ff;
  logic ref_pin_en_ff;
  logic current_source_output_en_ff;
  logic trig_ext_ff;
  logic [9:0] result_ff;

  // Conversion engine
  adcs_state_e state_ff;
  adcs_state_e nxt_state;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic first_ff;
  logic amp_ff;
  logic [11:0] samp_ff;
  logic strobe_ff;
  logic trig_prev_ff;
  logic halt_prev_ff;

  logic tick;
  logic trig_sync;
  logic [4:0] conv_len;
  logic [4:0] sh_point;
  logic last_cycle;
  logic start_now;
  logic complete;
  logic free_run;
  logic keep_running;
  logic trig_edge;
  logic trig_start;
  logic sleep_start;
  logic sw_start;
  logic sw_done_clr;
  logic en_rise;
  logic [7:0] ctrl_a_rd;
  logic [7:0] ctrl_b_rd;

  adcs_sync #(
    .W(1)
  ) u_trig_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din(ext_trigger),
    .dout(trig_sync)
  );

  // Trigger realigns the prescaler so the start delay is fixed
  adcs_presc #(
    .W(8)
  ) u_presc (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .enable(en_ff),
    .restart(trig_start),
    .sel(ps_ff),
    .tick(tick)
  );

  // Wishbone classic: ack one cycle after the request, write commits on the ack edge
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_fire = req && wb_we_i && ack_ff;
  assign wr_lane0 = wr_fire && wb_sel_i[0];

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  assign ctrl_a_rd = {en_ff, start_ff, ate_ff, done_ff, ie_ff, 2'h0, 1'b0} | {5'h00, ps_ff};
  assign ctrl_b_rd = {2'h0, ref_pin_en_ff, current_source_output_en_ff, 3'h0, trig_ext_ff};

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (req && !ack_ff) begin
      unique case (wb_adr_i)
        OFS_SELECT: rdata_ff <= {24'h00_0000, sel_hold_ff};
        OFS_CTRL_A: rdata_ff <= {24'h00_0000, ctrl_a_rd};
        OFS_CTRL_B: rdata_ff <= {24'h00_0000, ctrl_b_rd};
        OFS_RESULT: rdata_ff <= {22'h00_0000, result_ff};
        OFS_STATUS: rdata_ff <= {22'h00_0000, busy, first_ff, applied_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // Holding register: software has random access, the converter never sees it directly
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sel_hold_ff <= RST_SELECT;
    end else if (wr_lane0 && wb_adr_i == OFS_SELECT) begin
      sel_hold_ff <= wb_dat_i[7:0]; // RQ1
    end
  end

  // Start and done write decode
  assign sw_start = wr_lane0 && wb_adr_i == OFS_CTRL_A && wb_dat_i[BIT_START];
  assign sw_done_clr = wr_lane0 && wb_adr_i == OFS_CTRL_A && wb_dat_i[BIT_DONE];
  assign en_rise = wr_lane0 && wb_adr_i == OFS_CTRL_A && wb_dat_i[BIT_EN] && !en_ff;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      en_ff <= 1'b0;
      ate_ff <= 1'b0;
      ie_ff <= 1'b0;
      ps_ff <= RST_PS;
    end else if (wr_lane0 && wb_adr_i == OFS_CTRL_A) begin
      // Sleep entry leaves this alone; only software powers the converter down
      en_ff <= wb_dat_i[BIT_EN]; // RQ15
      ate_ff <= wb_dat_i[BIT_ATE];
      ie_ff <= wb_dat_i[BIT_IE];
      ps_ff <= wb_dat_i[PS_LSB+:3];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ref_pin_en_ff <= 1'b0;
      current_source_output_en_ff <= 1'b0;
      trig_ext_ff <= 1'b0;
    end else if (wr_lane0 && wb_adr_i == OFS_CTRL_B) begin
      ref_pin_en_ff <= wb_dat_i[BIT_REFPIN];
      current_source_output_en_ff <= wb_dat_i[BIT_CURRENT_SOURCE_OUTPUT];
      trig_ext_ff <= wb_dat_i[BIT_TRIGEXT];
    end
  end

  // Start sources
  assign trig_edge = trig_sync && !trig_prev_ff;
  // Edges seen while converting are dropped
  assign trig_start = en_ff && ate_ff && trig_ext_ff && trig_edge && state_ff == ST_IDLE && !start_ff;
  assign free_run = ate_ff && !trig_ext_ff;
  assign sleep_start = en_ff && !ate_ff && ie_ff && state_ff == ST_IDLE && !start_ff
                    && (sleep_mode == SLP_IDLE || sleep_mode == SLP_NR)
                    && cpu_halted && !halt_prev_ff; // RQ13

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      trig_prev_ff <= 1'b0;
      halt_prev_ff <= 1'b0;
    end else begin
      trig_prev_ff <= trig_sync;
      halt_prev_ff <= cpu_halted;
    end
  end

  // Conversion timing
  assign conv_len = first_ff ? CYC_FIRST : CYC_NORMAL; // RQ19
  assign sh_point = first_ff ? SH_FIRST : SH_NORMAL;
  assign last_cycle = state_ff == ST_CONV && cnt_ff == conv_len - 5'd1;
  assign start_now = en_ff && tick && state_ff == ST_IDLE && start_ff;
  assign complete = tick && last_cycle;
  // The gain stage cannot free run, so it stops after each conversion
  assign keep_running = free_run && !amp_ff; // RQ8

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    if (!en_ff) begin
      nxt_state = ST_IDLE;
      nxt_cnt = 5'd0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (start_now) begin
            nxt_state = ST_CONV;
            nxt_cnt = 5'd0;
          end
        end
        ST_CONV: begin
          if (complete) begin
            // Free running starts the next one at once with the selection just copied
            nxt_state = keep_running ? ST_CONV : ST_IDLE; // RQ7
            nxt_cnt = 5'd0;
          end else if (tick) begin
            nxt_cnt = cnt_ff + 5'd1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 5'd0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Applied selection: frozen during a conversion, copied on ADC edges otherwise
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      applied_ff <= RST_SELECT;
    end else if (tick && (state_ff == ST_IDLE || last_cycle)) begin
      applied_ff <= sel_hold_ff; // RQ1 RQ2 RQ20 RQ4
    end
  end

  // Gain path is decided by the selection that the conversion locked in
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      amp_ff <= 1'b0;
    end else if (tick && (state_ff == ST_IDLE || last_cycle)) begin
      amp_ff <= sel_hold_ff[CH_LSB+:4] >= AMP_CH_FIRST;
    end
  end

  // First conversion after enable takes the long sequence
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      first_ff <= 1'b0;
    end else if (en_rise) begin
      first_ff <= 1'b1; // RQ19
    end else if (complete) begin
      first_ff <= 1'b0;
    end
  end

  // Sample and hold point
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      samp_ff <= 12'h000;
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= tick && state_ff == ST_CONV && cnt_ff == sh_point;
      if (tick && state_ff == ST_CONV && cnt_ff == sh_point) begin
        samp_ff <= sample_in;
      end
    end
  end

  // Result register, saturated to full scale
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      result_ff <= 10'h000;
    end else if (complete) begin
      result_ff <= (samp_ff > {2'h0, FULL_SCALE}) ? FULL_SCALE : samp_ff[9:0]; // RQ11 RQ18
    end
  end

  // Done flag: a completion in the clearing cycle still sets it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= complete || (done_ff && !sw_done_clr); // RQ18 RQ2
    end
  end

  // Start bit: reads high through the whole conversion, set wins over hardware clear
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      start_ff <= 1'b0;
    end else if (sw_start || trig_start || sleep_start) begin
      start_ff <= en_ff || sw_start;
    end else if (!en_ff) begin
      start_ff <= 1'b0;
    end else if (complete && !keep_running) begin
      start_ff <= 1'b0; // RQ18 RQ8
    end
  end

  // Completion request stays up until software clears the flag, whatever woke the CPU
  assign conv_done_irq = done_ff && ie_ff; // RQ14

  assign busy = start_ff || state_ff == ST_CONV;

  // Analog side controls
  always_comb begin
    analog_o = '0;
    // Same code on both differential inputs passes straight to the mux
    analog_o.channel = applied_ff[CH_LSB+:4]; // RQ16
    analog_o.ref_avcc = applied_ff[REF_LSB+:2] == REF_AVCC; // RQ10
    analog_o.ref_int = applied_ff[REF_LSB+:2] == REF_INT; // RQ10
    // Current source on the shared pin isolates it from the reference network
    analog_o.ref_pin_connect = ref_pin_en_ff && !current_source_output_en_ff; // RQ12
    analog_o.current_source_output_drive = current_source_output_en_ff; // RQ12
    analog_o.powered = en_ff; // RQ15
    analog_o.sample_strobe = strobe_ff;
  end

endmodule : adcs_sequencer
`default_nettype wire

// >>> verif/adcs_sequencer_monitor.sv
/*
  Concurrent checks on the ports of the selection sequencer.
  Assumes it is bound to adcs_sequencer and sees nothing but its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module adcs_sequencer_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire adcs_pkg::adcs_analog_s analog_o,
  input wire logic conv_done_irq,
  input wire logic busy
);
  import adcs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_ack_one_cycle: assert property (s_req |=> s_ack_pulse)
    else $error("bus answer not a single cycle after request");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > OFS_STATUS |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:10] == 22'h0)
    else $error("read data upper bits set");
  a_ref_exclusive: assert property (!(analog_o.ref_avcc && analog_o.ref_int))
    else $error("two references connected");
  a_current_source_output_isolates: assert property (analog_o.current_source_output_drive |-> !analog_o.ref_pin_connect)
    else $error("reference pin joined while current source drives");
  // Selection must not move for eight system clocks starting at the sampling strobe
  a_sel_locked: assert property (analog_o.sample_strobe |->
    ($stable({analog_o.channel, analog_o.ref_avcc, analog_o.ref_int}))[*8])
    else $error("selection moved during conversion");
  a_strobe_in_conv: assert property (analog_o.sample_strobe |-> busy ##1 !analog_o.sample_strobe)
    else $error("sample strobe outside conversion or too long");
  a_irq_clear_write: assert property ($past(nrst) && $fell(conv_done_irq) |-> $past(wb_ack_o && wb_we_i))
    else $error("completion request dropped without a write");
  a_irq_at_done: assert property ($rose(conv_done_irq) && !$past(wb_ack_o) |-> $fell(busy) || busy)
    else $error("completion request without a conversion end");
endmodule : adcs_sequencer_monitor

bind adcs_sequencer adcs_sequencer_monitor i_adcs_sequencer_monitor (.clk_sys(clk_sys), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .analog_o(analog_o), .conv_done_irq(conv_done_irq), .busy(busy));
`default_nettype wire

// >>> verif/adcs_sequencer_tb.sv
/*
  Self-checking bench for the selection sequencer.
  Assumes prescale 0, so one ADC clock is two system clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module adcs_sequencer_tb;
  import adcs_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic ext_trigger = 1'b0;
  logic [11:0] sample_in = 12'h000;
  adcs_sleep_e sleep_mode = SLP_NONE;
  logic cpu_halted = 1'b0;
  adcs_analog_s analog_o;
  logic conv_done_irq;
  logic busy;
  logic [31:0] rd;
  int cnt;
  int err_total = 0;
  int n_compared = 0;

  always #25 clk_sys = ~clk_sys;

  adcs_sequencer i_adcs_sequencer (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_trigger(ext_trigger), .sample_in(sample_in), .sleep_mode(sleep_mode),
    .cpu_halted(cpu_halted), .analog_o(analog_o), .conv_done_irq(conv_done_irq), .busy(busy));

  task automatic finish_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle: hold everything until ack is sampled, then release
  task automatic xfer(input logic we, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    // No cycle limit here: only the watchdog ends a hung cycle
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rd, e);
  endtask : rdc

  // k: 0 idle, 1 done request, 2 sample strobe, 3 busy
  task automatic wait_on(input int k, input int lim);
    cnt = 0;
    do begin
      @(posedge clk_sys);
      cnt++;
    end while ((k == 0 ? busy !== 1'b0 : k == 1 ? conv_done_irq !== 1'b1 :
      k == 2 ? analog_o.sample_strobe !== 1'b1 : busy !== 1'b1) && cnt < lim);
  endtask : wait_on

  task automatic t_reset();
    chk(32'({analog_o, busy, conv_done_irq}), 32'h0);
    rdc(OFS_SELECT, 32'h0);
    rdc(OFS_CTRL_A, 32'h0);
    wr(5'h14, 8'hFF);
    rdc(5'h14, 32'h0);
    wb_sel_i <= 4'hE;
    wr(OFS_SELECT, 8'h0F);
    wb_sel_i <= 4'hF;
    rdc(OFS_SELECT, 32'h0);
  endtask : t_reset

  task automatic t_first();
    sample_in <= 12'h0A5;
    wr(OFS_SELECT, 8'h45);
    wr(OFS_CTRL_A, 8'h80);
    wr(OFS_CTRL_A, 8'hC8);
    wr(OFS_SELECT, 8'h47);
    chk({28'h0, analog_o.channel}, 32'h5);
    wait_on(0, 3000);
    // Start tick lies two edges before the count, busy is seen low one edge after the end
    chk(32'(cnt + 1), 32'(2 * CYC_FIRST));
    chk({28'h0, analog_o.channel}, 32'h7);
    chk({31'h0, conv_done_irq}, 32'h1);
    rdc(OFS_CTRL_A, 32'h98);
    rdc(OFS_RESULT, 32'h0A5);
    rdc(OFS_STATUS, 32'h047);
  endtask : t_first

  task automatic t_norm();
    sample_in <= 12'hFFF;
    wr(OFS_CTRL_A, 8'h98);
    wr(OFS_CTRL_A, 8'hC8);
    chk({31'h0, conv_done_irq}, 32'h0);
    wait_on(0, 3000);
    // Start waits one or two edges for the ADC tick, busy is seen low one edge after the end
    chk(32'(cnt >= 2 * CYC_NORMAL + 2 && cnt <= 2 * CYC_NORMAL + 3), 32'h1);
    rdc(OFS_RESULT, 32'h3FF);
  endtask : t_norm

  // Changing channel in free running breaks advice on purpose to see the lag
  task automatic t_free();
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_SELECT, 8'h4B);
    // 125 us of gain stage settling at 50 ns per clock
    repeat (2500) @(posedge clk_sys);
    wr(OFS_CTRL_A, 8'hF8);
    wait_on(0, 3000);
    chk(32'(cnt >= 2 * CYC_NORMAL + 2 && cnt <= 2 * CYC_NORMAL + 3), 32'h1);
    wr(OFS_SELECT, 8'h42);
    wr(OFS_CTRL_A, 8'hF8);
    wait_on(1, 100);
    wr(OFS_SELECT, 8'h43);
    wait_on(2, 100);
    chk({28'h0, analog_o.channel}, 32'h2);
    wait_on(2, 100);
    chk({28'h0, analog_o.channel}, 32'h3);
    wr(OFS_CTRL_A, 8'h10);
  endtask : t_free

  task automatic t_sleep();
    adcs_sleep_e m[3] = '{SLP_DEEP, SLP_IDLE, SLP_NR};
    wr(OFS_CTRL_B, 8'h01);
    wr(OFS_CTRL_A, 8'h98);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      sleep_mode <= m[i];
      cpu_halted <= 1'b1;
      wait_on(3, 10);
      chk({31'h0, busy}, 32'(i != 0));
      chk({31'h0, analog_o.powered}, 32'h1);
      cpu_halted <= 1'b0;
      sleep_mode <= SLP_NONE;
      wait_on(0, 3000);
      chk({31'h0, conv_done_irq}, 32'(i != 0));
      wr(OFS_CTRL_A, 8'h98);
    end
  endtask : t_sleep

  task automatic t_ref();
    for (int r = 0; r < 4; r++) begin
      wr(OFS_SELECT, {r[1:0], 6'h0E});
      repeat (3) @(posedge clk_sys);
      chk(32'({analog_o.channel, analog_o.ref_avcc, analog_o.ref_int}), 32'({4'hE, r == 1, r == 3}));
    end
    wr(OFS_CTRL_B, 8'h30);
    @(posedge clk_sys);
    chk(32'({analog_o.current_source_output_drive, analog_o.ref_pin_connect}), 32'h2);
    rdc(OFS_CTRL_B, 32'h30);
    wr(OFS_CTRL_B, 8'h20);
    @(posedge clk_sys);
    chk(32'({analog_o.current_source_output_drive, analog_o.ref_pin_connect}), 32'h1);
  endtask : t_ref

  // External trigger: a selection written mid-conversion waits for the next one, late edges are dropped
  task automatic t_trig();
    wr(OFS_CTRL_B, 8'h01);
    wr(OFS_SELECT, 8'h41);
    wr(OFS_CTRL_A, 8'hB8);
    ext_trigger <= 1'b1;
    wait_on(3, 10);
    // Two synchroniser edges, one edge detect, then the start bit shows
    chk(32'(cnt), 32'h4);
    ext_trigger <= 1'b0;
    wr(OFS_SELECT, 8'h46);
    chk({28'h0, analog_o.channel}, 32'h1);
    ext_trigger <= 1'b1;
    wait_on(0, 3000);
    // Prescaler realigned by the trigger: start tick two edges later, so a fixed length
    chk(32'(cnt), 32'(2 * CYC_NORMAL - 1));
    chk({28'h0, analog_o.channel}, 32'h6);
    repeat (40) @(posedge clk_sys);
    chk({31'h0, busy}, 32'h0);
    chk({31'h0, conv_done_irq}, 32'h1);
    ext_trigger <= 1'b0;
  endtask : t_trig

  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_first();
    t_norm();
    t_free();
    t_sleep();
    t_ref();
    t_trig();
    finish_test();
  end

  // All scenarios need well under five thousand cycles, the settling wait included
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
endmodule : adcs_sequencer_tb
`default_nettype wire
